// ==== bench/jtap_tap_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module jtap_tap_tb_top;
  import jtap_pkg::*;
  logic         i_ref_clk, i_rstn, tck, tms, tdi, trst_n, tdo, tdo_oe, b;
  logic [7:0]   bsr_cap, bsr_upd;
  logic [2:0]   instr;
  logic [31:0]  got;
  jtap_pinctl_s pinctl;
  jtap_state_e  state;
  int           err_count, n_compared;

  jtap_tap #(.BSR_W(8)) jtap_tap_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_bsr_capture(bsr_cap),
    .o_bsr_update(bsr_upd), .o_pinctl(pinctl), .o_instr(instr), .o_state(state));
  jtap_tester jtap_tester_i (.i_ref_clk(i_ref_clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck),
    .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // walk the controller, tms bits taken lsb first
  task automatic go(input logic [7:0] seq, input int n);
    for (int k = 0; k < n; k++) jtap_tester_i.step(seq[k], 1'b0, b);
  endtask : go

  // shift n bits lsb first, leaving with tms high on the last one
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    for (int k = 0; k < n; k++) begin
      jtap_tester_i.step(k == n - 1, din[k], b);
      dout[k] = b;
      `CHK(jtap_tester_i.seen_oe, 1'b1)
    end
  endtask : shift

  task automatic load_ir(input logic [2:0] code);
    logic [2:0] prev;
    prev = instr;
    go(8'b0011, 4);
    shift(3, {29'h0, code}, got);
    `CHK(got[2:0], JTAP_IR_CAPTURE)
    go(8'b1, 1);
    `CHK(state, JTAP_UPD_IR)
    `CHK(instr, prev)
    go(8'b0, 1);
    `CHK(instr, code)
  endtask : load_ir

  task automatic shift_dr(input int n, input logic [31:0] din);
    go(8'b001, 3);
    shift(n, din, got);
    go(8'b01, 2);
  endtask : shift_dr

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_ident();
    `CHK(state, JTAP_RESET)
    `CHK(instr, JTAP_IDENTIFY)
    `CHK(tdo_oe, 1'b0)
    go(8'b0, 1);
    shift_dr(32, 32'hFFFF_0000);
    `CHK(got, JTAP_ID_DEFAULT)
    `CHK(got[0], 1'b1)
    $display("test ident done");
  endtask : t_ident

  // every code: pin controls and, for the one-bit paths, capture zero then one-bit delay
  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      load_ir(3'(c));
      `CHK(pinctl, jtap_pinctl_s'{c == 0 || c == 6, c == 5, c == 6})
      if (c inside {2, 3, 5, 6, 7}) begin
        shift_dr(4, 32'hB);
        `CHK(got[3:0], 4'h6)
      end
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_sample();
    load_ir(JTAP_SAMPLE_PRELOAD);
    shift_dr(8, 32'h3C);
    `CHK(got[7:0], 8'hA5)
    `CHK(bsr_upd, 8'h3C)
    `CHK(pinctl, jtap_pinctl_s'(3'h0))
    load_ir(JTAP_BOUNDARY_DRIVE);
    `CHK(pinctl.drive_update, 1'b1)
    `CHK(bsr_upd, 8'h3C)
    $display("test sample done");
  endtask : t_sample

  // five high mode edges from shift-dr, not four
  task automatic t_five();
    load_ir(JTAP_BYPASS);
    go(8'b001, 3);
    go(8'hF, 4);
    `CHK(state, JTAP_SEL_IR)
    go(8'b1, 1);
    `CHK(state, JTAP_RESET)
    go(8'b0, 1);
    `CHK(instr, JTAP_IDENTIFY)
    $display("test five done");
  endtask : t_five

  // test reset in mid shift, tck standing still
  task automatic t_trst();
    load_ir(JTAP_HIGH_IMPEDANCE);
    go(8'b001, 3);
    jtap_tester_i.test_reset();
    `CHK(state, JTAP_RESET)
    `CHK(instr, JTAP_IDENTIFY)
    `CHK(pinctl.force_hiz, 1'b0)
    `CHK(tdo_oe, 1'b0)
    $display("test trst done");
  endtask : t_trst

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  // 250 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // main sequence
  initial begin
    i_rstn = 1'b0;
    bsr_cap = 8'hA5;
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    t_ident();
    t_codes();
    t_sample();
    t_five();
    t_trst();
    complete_run();
  end
endmodule : jtap_tap_tb_top

// ==== bench/jtap_tester.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// external boundary-scan tester model
// ----------------------------------------------------------------
module jtap_tester (
  input  wire logic i_ref_clk,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  output logic      o_trst_n
);
  logic seen_oe;

  // pins idle high like the pull-ups they replace
  initial begin
    o_tck = 1'b1;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_trst_n = 1'b1;
    seen_oe = 1'b0;
  end

  // one test clock period of 128 ns; tck stands high between frames
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_ref_clk);
    o_tck <= 1'b0;
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (16) @(posedge i_ref_clk);
    tdo = i_tdo;
    seen_oe = i_tdo_oe;
    o_tck <= 1'b1;
    repeat (15) @(posedge i_ref_clk);
  endtask : step

  // test reset pulse, long enough to pass the input synchroniser
  task automatic test_reset();
    @(posedge i_ref_clk);
    o_trst_n <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    o_trst_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
  endtask : test_reset
endmodule : jtap_tester

// ==== pkg/jtap_pkg.sv ====
package jtap_pkg;

  // ---------------------------------------------------------------
  // controller states (standard 4-bit encoding)
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    JTAP_RESET   = 4'hF,
    JTAP_IDLE    = 4'hC,
    JTAP_SEL_DR  = 4'h7,
    JTAP_CAP_DR  = 4'h6,
    JTAP_SH_DR   = 4'h2,
    JTAP_EX1_DR  = 4'h1,
    JTAP_PAU_DR  = 4'h3,
    JTAP_EX2_DR  = 4'h0,
    JTAP_UPD_DR  = 4'h5,
    JTAP_SEL_IR  = 4'h4,
    JTAP_CAP_IR  = 4'hE,
    JTAP_SH_IR   = 4'hA,
    JTAP_EX1_IR  = 4'h9,
    JTAP_PAU_IR  = 4'hB,
    JTAP_EX2_IR  = 4'h8,
    JTAP_UPD_IR  = 4'hD
  } jtap_state_e;

  // ---------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------
  localparam int          JTAP_IR_W             = 3;
  localparam logic [2:0]  JTAP_BOUNDARY_DRIVE   = 3'h0;
  localparam logic [2:0]  JTAP_IDENTIFY         = 3'h1;
  localparam logic [2:0]  JTAP_SAMPLE_PRELOAD   = 3'h4;
  localparam logic [2:0]  JTAP_HIGH_IMPEDANCE   = 3'h5;
  localparam logic [2:0]  JTAP_CLAMP            = 3'h6;
  localparam logic [2:0]  JTAP_BYPASS           = 3'h7;
  localparam logic [2:0]  JTAP_IR_CAPTURE       = 3'h1;
  localparam int          JTAP_ID_W             = 32;
  localparam logic [31:0] JTAP_ID_DEFAULT       = 32'h0000_0001; // arbitrary identity value
  localparam int          JTAP_RESET_EDGES      = 5;

  // pin-side controls
  typedef struct packed {
    logic drive_update;  // pins driven from update cells
    logic force_hiz;     // every output released
    logic func_reset;    // functional reset asserted
  } jtap_pinctl_s;

endpackage : jtap_pkg

// ==== rtl/jtap_tap.sv ====
`timescale 1ns/10ps
// Behaviour
// - mode select sampled on test clock rise
// - five high mode edges reach reset
// - instruction shifter is three bits, no parity
// - update-ir fall copies shifter to hold
// - shifter msb at data in, lsb out
// - code 000 boundary path, drive update cells
// - boundary cells set direction and hiz
// - code 001 selects 32-bit identification path
// - identification capture loads lsb one
// - any test reset holds identify instruction
// - capture-ir loads shifter with one
// - code 100 captures pins in capture-dr
// - sample shifts without disturbing system
// - update-dr fall loads boundary update cells
// - high impedance selects bypass, releases pins
// - high impedance applies on update-ir fall
// - code 110 bypass, functional reset, clamp
// - code 111 bypass captures zero
// - data out changes on fall, else hiz
// - test reset forces reset synchronously, after the two-flop pin synchroniser
module jtap_tap #(
  parameter int BSR_W = 8
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_tck,
  input  wire logic                 i_tms,
  input  wire logic                 i_tdi,
  input  wire logic                 i_trst_n,
  output logic                      o_tdo,
  output logic                      o_tdo_oe,
  input  wire logic [BSR_W-1:0]     i_bsr_capture,
  output logic      [BSR_W-1:0]     o_bsr_update,
  output jtap_pkg::jtap_pinctl_s    o_pinctl,
  output logic      [2:0]           o_instr,
  output jtap_pkg::jtap_state_e     o_state
);
  import jtap_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers and test clock edge detection
  // ---------------------------------------------------------------
  logic [1:0] tck_s_r, tms_s_r, tdi_s_r, trst_s_r;
  logic       tck_d_r;
  logic       rise, fall, trst_n;

  // two flops per pin; only the second stage is read
  // the test clock stage resets to its idle high level: resetting it low would
  // fake a rising edge on the first clock after reset and step the controller
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tck_s_r  <= 2'h3;
      tms_s_r  <= 2'h3;
      tdi_s_r  <= 2'h3;
      trst_s_r <= 2'h0;
      tck_d_r  <= 1'h1;
    end else begin
      tck_s_r  <= {tck_s_r[0], i_tck};
      tms_s_r  <= {tms_s_r[0], i_tms};
      tdi_s_r  <= {tdi_s_r[0], i_tdi};
      trst_s_r <= {trst_s_r[0], i_trst_n};
      tck_d_r  <= tck_s_r[1];
    end
  end

  assign rise   = tck_s_r[1] & ~tck_d_r;
  assign fall   = ~tck_s_r[1] & tck_d_r;
  assign trst_n = trst_s_r[1];

  // ---------------------------------------------------------------
  // controller state machine
  // ---------------------------------------------------------------
  jtap_state_e state_r, state_nxt;

  // standard 16-state walk, mode select decides each step
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      JTAP_RESET:  state_nxt = tms_s_r[1] ? JTAP_RESET  : JTAP_IDLE;
      JTAP_IDLE:   state_nxt = tms_s_r[1] ? JTAP_SEL_DR : JTAP_IDLE;
      JTAP_SEL_DR: state_nxt = tms_s_r[1] ? JTAP_SEL_IR : JTAP_CAP_DR;
      JTAP_CAP_DR: state_nxt = tms_s_r[1] ? JTAP_EX1_DR : JTAP_SH_DR;
      JTAP_SH_DR:  state_nxt = tms_s_r[1] ? JTAP_EX1_DR : JTAP_SH_DR;
      JTAP_EX1_DR: state_nxt = tms_s_r[1] ? JTAP_UPD_DR : JTAP_PAU_DR;
      JTAP_PAU_DR: state_nxt = tms_s_r[1] ? JTAP_EX2_DR : JTAP_PAU_DR;
      JTAP_EX2_DR: state_nxt = tms_s_r[1] ? JTAP_UPD_DR : JTAP_SH_DR;
      JTAP_UPD_DR: state_nxt = tms_s_r[1] ? JTAP_SEL_DR : JTAP_IDLE;
      JTAP_SEL_IR: state_nxt = tms_s_r[1] ? JTAP_RESET  : JTAP_CAP_IR;
      JTAP_CAP_IR: state_nxt = tms_s_r[1] ? JTAP_EX1_IR : JTAP_SH_IR;
      JTAP_SH_IR:  state_nxt = tms_s_r[1] ? JTAP_EX1_IR : JTAP_SH_IR;
      JTAP_EX1_IR: state_nxt = tms_s_r[1] ? JTAP_UPD_IR : JTAP_PAU_IR;
      JTAP_PAU_IR: state_nxt = tms_s_r[1] ? JTAP_EX2_IR : JTAP_PAU_IR;
      JTAP_EX2_IR: state_nxt = tms_s_r[1] ? JTAP_UPD_IR : JTAP_SH_IR;
      JTAP_UPD_IR: state_nxt = tms_s_r[1] ? JTAP_SEL_DR : JTAP_IDLE;
    endcase
  end

  // state steps only on a sampled rising test clock edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= JTAP_RESET;
    end else if (!trst_n) begin
      state_r <= JTAP_RESET;
    end else if (rise) begin
      state_r <= state_nxt;
    end
  end

  assign o_state = state_r;

  // ---------------------------------------------------------------
  // instruction shifter and hold stage
  // ---------------------------------------------------------------
  logic [JTAP_IR_W-1:0] ir_sh_r, ir_hold_r;

  // msb takes data in, lsb leaves first
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ir_sh_r <= JTAP_IR_CAPTURE;
    end else if (rise) begin
      if (state_r == JTAP_CAP_IR) begin
        ir_sh_r <= JTAP_IR_CAPTURE;
      end else if (state_r == JTAP_SH_IR) begin
        ir_sh_r <= {tdi_s_r[1], ir_sh_r[JTAP_IR_W-1:1]};
      end
    end
  end

  // hold stage changes on the falling edge so pins never glitch mid-shift
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ir_hold_r <= JTAP_IDENTIFY;
    end else if (!trst_n || (fall && state_r == JTAP_RESET)) begin
      ir_hold_r <= JTAP_IDENTIFY;
    end else if (fall && state_r == JTAP_UPD_IR) begin
      ir_hold_r <= ir_sh_r;
    end
  end

  assign o_instr = ir_hold_r;

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  logic sel_bsr, sel_id;

  // everything not boundary or identify falls to bypass
  assign sel_bsr = (ir_hold_r == JTAP_BOUNDARY_DRIVE) || (ir_hold_r == JTAP_SAMPLE_PRELOAD);
  assign sel_id  = (ir_hold_r == JTAP_IDENTIFY);

  // pin controls from flops; sample/preload leaves the system alone
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pinctl <= '0;
    end else begin
      o_pinctl.drive_update <= (ir_hold_r == JTAP_BOUNDARY_DRIVE) || (ir_hold_r == JTAP_CLAMP);
      o_pinctl.force_hiz    <= (ir_hold_r == JTAP_HIGH_IMPEDANCE);
      o_pinctl.func_reset   <= (ir_hold_r == JTAP_CLAMP);
    end
  end

  // ---------------------------------------------------------------
  // data registers
  // ---------------------------------------------------------------
  logic [BSR_W-1:0]     bsr_sh_r;
  logic [JTAP_ID_W-1:0] id_sh_r;
  logic                 byp_r;

  // capture then shift; pins are sampled with no clock sync (tester's job)
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bsr_sh_r <= '0;
      id_sh_r  <= '0;
      byp_r    <= 1'h0;
    end else if (rise) begin
      if (state_r == JTAP_CAP_DR) begin
        if (sel_bsr) bsr_sh_r <= i_bsr_capture;
        if (sel_id)  id_sh_r  <= JTAP_ID_DEFAULT;
        byp_r <= 1'h0;
      end else if (state_r == JTAP_SH_DR) begin
        if (sel_bsr) bsr_sh_r <= {tdi_s_r[1], bsr_sh_r[BSR_W-1:1]};
        if (sel_id)  id_sh_r  <= {tdi_s_r[1], id_sh_r[JTAP_ID_W-1:1]};
        byp_r <= tdi_s_r[1];
      end
    end
  end

  // update cells load on update-dr fall, only under boundary instructions
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bsr_update <= '0;
    end else if (fall && state_r == JTAP_UPD_DR && sel_bsr) begin
      o_bsr_update <= bsr_sh_r;
    end
  end

  // ---------------------------------------------------------------
  // serial data out
  // ---------------------------------------------------------------
  logic tdo_bit;

  always_comb begin
    if (state_r == JTAP_SH_IR) tdo_bit = ir_sh_r[0];
    else if (sel_bsr)          tdo_bit = bsr_sh_r[0];
    else if (sel_id)           tdo_bit = id_sh_r[0];
    else                       tdo_bit = byp_r;
  end

  // output moves on fall; released whenever not shifting
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tdo    <= 1'h0;
      o_tdo_oe <= 1'h0;
    end else if (!trst_n) begin
      o_tdo_oe <= 1'h0;
    end else if (fall) begin
      o_tdo    <= tdo_bit;
      o_tdo_oe <= (state_r == JTAP_SH_DR) || (state_r == JTAP_SH_IR);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [2:0] tms_hi_cnt;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) tms_hi_cnt <= 3'h0;
    else if (rise) tms_hi_cnt <= !tms_s_r[1] ? 3'h0 : (tms_hi_cnt == 3'h5 ? 3'h5 : tms_hi_cnt + 3'h1);
  end

  AST_FIVE_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (tms_hi_cnt == 3'h5) |-> state_r == JTAP_RESET) else $error("five high edges did not reset");
  AST_TRST: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !trst_n |=> state_r == JTAP_RESET) else $error("test reset ignored");
  AST_CAP_IR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (rise && trst_n && state_r == JTAP_CAP_IR) |=> ir_sh_r == JTAP_IR_CAPTURE) else $error("capture-ir value wrong");
  AST_UPD_IR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (fall && trst_n && state_r == JTAP_UPD_IR) |=> ir_hold_r == $past(ir_sh_r)) else $error("hold not updated");
  AST_ID_RESET: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (fall && state_r == JTAP_RESET) |=> ir_hold_r == JTAP_IDENTIFY) else $error("reset did not select identify");
  AST_BYP_CAP: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (rise && trst_n && state_r == JTAP_CAP_DR) |=> !byp_r) else $error("bypass capture not zero");
  AST_ID_LSB: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (rise && trst_n && state_r == JTAP_CAP_DR && sel_id) |=> id_sh_r[0]) else $error("identify lsb not one");
  AST_HIZ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (ir_hold_r == JTAP_HIGH_IMPEDANCE) |=> o_pinctl.force_hiz && !o_pinctl.drive_update) else $error("hiz not forced");
  AST_TDO_OE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (fall && state_r == JTAP_IDLE) |=> !o_tdo_oe) else $error("data out driven while idle");

  // ---------------------------------------------------------------
  // further checks on stepping, hold stage and pin controls
  // ---------------------------------------------------------------
  // synchronised data in, named so that sampled-value calls see a plain signal
  logic tdi_q;
  assign tdi_q = tdi_s_r[1];

  // no test clock rise and no test reset: the controller must not move
  AST_STEP_ON_RISE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (trst_n && !rise)
    |=> $stable(state_r)) else $error("state moved without a test clock rise");

  // on a rise the controller takes the step that mode select picked
  AST_NEXT_STATE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (rise && trst_n)
    |=> state_r == $past(state_nxt)) else $error("state step wrong");

  // a test reset leaves identify in the hold stage
  AST_TRST_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !trst_n
    |=> ir_hold_r == JTAP_IDENTIFY) else $error("test reset did not select identify");

  // the hold stage only moves on a fall or a test reset, so pins never glitch mid-shift
  AST_HOLD_STABLE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (trst_n && !fall)
    |=> $stable(ir_hold_r)) else $error("hold stage moved off a falling edge");

  // the bit next to data in takes the sampled data in bit
  AST_IR_MSB_IN: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (rise && trst_n && state_r == JTAP_SH_IR)
    |=> ir_sh_r[JTAP_IR_W-1] == $past(tdi_q)) else $error("instruction msb not from data in");

  // the three-bit shifter only moves on a rising edge
  AST_IR_QUIET: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !rise
    |=> $stable(ir_sh_r)) else $error("instruction shifter moved off a rising edge");

  // boundary capture takes the pin values as they stood
  AST_BSR_CAP: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (rise && trst_n && state_r == JTAP_CAP_DR && sel_bsr)
    |=> bsr_sh_r == $past(i_bsr_capture)) else $error("boundary capture wrong");

  // the whole identification word is loaded at capture
  AST_ID_CAP_ALL: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (rise && trst_n && state_r == JTAP_CAP_DR && sel_id)
    |=> id_sh_r == JTAP_ID_DEFAULT) else $error("identification capture wrong");

  // update cells copy the shifter on the update-dr fall
  AST_UPD_DR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (fall && state_r == JTAP_UPD_DR && sel_bsr)
    |=> o_bsr_update == $past(bsr_sh_r)) else $error("update cells not loaded");

  // and keep their value at every other time
  AST_UPD_KEEP: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (!fall || state_r != JTAP_UPD_DR)
    |=> $stable(o_bsr_update)) else $error("update cells changed outside update-dr");

  // boundary drive puts the update cells on the pins, no functional reset
  AST_BOUNDARY: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (ir_hold_r == JTAP_BOUNDARY_DRIVE)
    |=> o_pinctl.drive_update && !o_pinctl.func_reset) else $error("boundary drive not applied");

  // clamp drives the update cells and holds the system in reset
  AST_CLAMP: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (ir_hold_r == JTAP_CLAMP)
    |=> o_pinctl.func_reset && o_pinctl.drive_update && !o_pinctl.force_hiz) else $error("clamp not applied");

  // sample/preload leaves the system alone
  AST_SAMPLE_QUIET: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (ir_hold_r == JTAP_SAMPLE_PRELOAD)
    |=> o_pinctl == '0) else $error("sample disturbed the pins");

  // the bypass bit takes data in while shifting
  AST_BYP_SHIFT: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (rise && trst_n && state_r == JTAP_SH_DR)
    |=> byp_r == $past(tdi_q)) else $error("bypass bit did not shift");

  // data out only moves after a falling edge
  AST_TDO_FALL: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !fall
    |=> $stable(o_tdo)) else $error("data out moved off a falling edge");

  // data out is driven through a data shift
  AST_OE_SHIFT: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (fall && trst_n && state_r == JTAP_SH_DR)
    |=> o_tdo_oe) else $error("data out not driven while shifting");

  // a test reset releases data out at once, even mid-shift
  AST_OE_TRST: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !trst_n
    |=> !o_tdo_oe) else $error("data out driven during test reset");

endmodule : jtap_tap
